// >>> rtl/mds_pkg.sv
// Purpose: Shared constants and types for the module identity and diagnostics serial target
// Assumes: 100 MHz system clock; serial bus pins are sampled, not used as clocks
// Notes:   Diagnostics layout follows the usual threshold, live value and flag placement
package mds_pkg;
  // Target addresses, 7-bit form of 1010000X and 1010001X
  localparam logic [6:0] ADDR_ID       = 7'h50;
  localparam logic [6:0] ADDR_DIAG     = 7'h51;
  localparam int         MEM_DEPTH     = 256;
  // Diagnostics area layout
  localparam logic [7:0] THR_STRIDE    = 8'h08;
  localparam logic [7:0] THR_LO_ALARM  = 8'h02;
  localparam logic [7:0] THR_HI_WARN   = 8'h04;
  localparam logic [7:0] THR_LO_WARN   = 8'h06;
  localparam logic [7:0] LIVE_BASE     = 8'h60;
  localparam logic [7:0] LIVE_LAST     = 8'h69;
  localparam logic [7:0] ALARM_BYTE0   = 8'h70;
  localparam logic [7:0] ALARM_BYTE1   = 8'h71;
  localparam logic [7:0] WARN_BYTE0    = 8'h74;
  localparam logic [7:0] WARN_BYTE1    = 8'h75;
  localparam logic [7:0] USER_BASE     = 8'h80;
  // Identity byte that advertises the calibration mode
  localparam logic [7:0] ID_DIAG_TYPE  = 8'h5C;
  localparam logic [7:0] CAL_INT_MASK  = 8'h20;
  localparam int         NUM_MON       = 5;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Transmitter shutdown deadline
  localparam int         TX_OFF_MAX_NS = 10000;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         TX_OFF_CYCLES = TX_OFF_MAX_NS / CLK_PERIOD_NS;
  localparam int         SYNC_STAGES   = 2;

  // Live monitor readings, all 16 bit, temperature signed
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
  } mds_mon_t;

  // Factory load port for both memories
  typedef struct packed {
    logic       we;
    logic       diag_sel;
    logic [7:0] addr;
    logic [7:0] data;
  } mds_load_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK_A  = 3'b010,
    ST_WORD   = 3'b011,
    ST_ACK_W  = 3'b100,
    ST_WDATA  = 3'b101,
    ST_RDATA  = 3'b110,
    ST_MACK   = 3'b111
  } mds_state_t;
endpackage : mds_pkg

// >>> rtl/mds_target.sv
// Purpose: Two-wire serial target serving an identity map and a diagnostics map, plus status pins
// Assumes: Host clock and data pins and the status inputs are asynchronous to clock
// Notes:   Serial clock must stay below about an eighth of the system clock rate
// Function
// - Answer at address 1010000X with a 256-byte identity memory.
// - Answer at 1010001X with diagnostics, identity map left unchanged.
// - Take write data on clock rise, store only in unprotected bytes.
// - Change driven read data on the serial clock falling edge.
// - Both memories are bytes, reached singly or sequentially.
// - Keep live temperature, bias, powers and supply readable by host.
// - Set alarm and warning flags when a reading leaves its range.
// - Report diagnostics as internally calibrated by default.
// - No-light output low in normal reception, high without light.
// - Receive data output valid while the no-light output is low.
// - Transmitter off within 10 us of laser-off request.
// - Transmitter off while request high or open, on while low.
// - Laser-trouble output high on transmitter fault, low otherwise.
module mds_target
  import mds_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst,
  // Serial bus pins
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe,
  // Optical status pins
  input  wire logic      no_light_in,
  input  wire logic      rx_data_in,
  output logic           no_light_flag,
  output logic           rx_data_out,
  input  wire logic      laser_off_req,
  input  wire logic      laser_fault_in,
  output logic           laser_enable,
  output logic           laser_trouble,
  // Diagnostic monitor controller side
  input  wire mds_mon_t  mon,
  input  wire mds_load_t load
);

  logic [5:0]  sync1_reg;
  logic [5:0]  sync2_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  mds_state_t  state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        rw_reg;
  logic        tgt_reg;
  logic [7:0]  ptr_reg [2];
  logic        wr_pulse_reg;
  logic        wr_tgt_reg;
  logic [7:0]  wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic [7:0]  id_mem   [MEM_DEPTH];
  logic [7:0]  diag_mem [MEM_DEPTH];
  logic [9:0]  alarm_reg;
  logic [9:0]  warn_reg;
  logic [9:0]  alarm_next;
  logic [9:0]  warn_next;
  logic [79:0] mon_vec;
  logic        byte_done;
  logic [7:0]  rd_cur;

  // Pin idle levels: bus high, no light, shutdown requested, no fault, so no false status after reset
  localparam logic [5:0] SYNC_IDLE = 6'h3A;

  assign mon_vec   = mon;
  assign byte_done = (bit_cnt_reg == BITS_PER_BYTE);
  // Open drain: the pin is only ever pulled low
  assign sda_out   = 1'b0;

  // Threshold pair stored big-endian in the diagnostics memory
  function automatic logic [15:0] thr(input logic [7:0] a);
    thr = {diag_mem[a], diag_mem[8'(a + 8'h01)]};
  endfunction : thr

  function automatic logic cmp_gt(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    cmp_gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction : cmp_gt

  function automatic logic writable(input logic tgt, input logic [7:0] a);
    writable = tgt && (a >= USER_BASE);
  endfunction : writable

  // Byte seen by the host; live values and flags override the stored image
  function automatic logic [7:0] rd_byte(input logic tgt, input logic [7:0] a);
    logic [79:0] sh;
    logic [7:0]  idx;
    idx = 8'(a - LIVE_BASE);
    sh  = mon_vec << {idx, 3'b000};
    if (!tgt) begin
      rd_byte = (a == ID_DIAG_TYPE) ? (id_mem[a] | CAL_INT_MASK) : id_mem[a];
    end else if (a >= LIVE_BASE && a <= LIVE_LAST) begin
      rd_byte = sh[79:72];
    end else if (a == ALARM_BYTE0) begin
      rd_byte = alarm_reg[9:2];
    end else if (a == ALARM_BYTE1) begin
      rd_byte = {alarm_reg[1:0], 6'h00};
    end else if (a == WARN_BYTE0) begin
      rd_byte = warn_reg[9:2];
    end else if (a == WARN_BYTE1) begin
      rd_byte = {warn_reg[1:0], 6'h00};
    end else begin
      rd_byte = diag_mem[a];
    end
  endfunction : rd_byte

  // Byte at the active pointer, ready for the next load into the shifter
  always_comb begin
    rd_cur = rd_byte(tgt_reg, ptr_reg[tgt_reg]);
  end

  // Two-stage synchronisers for every pin input
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= {scl_in, sda_in, no_light_in, rx_data_in, laser_off_req, laser_fault_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign scl_s = sync2_reg[5];
  assign sda_s = sync2_reg[4];

  // Delayed copies for edge detection, taken from the second stage only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d_reg;
  assign scl_fall  = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Bus protocol engine; scl is only observed, never driven
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      rw_reg       <= 1'b0;
      tgt_reg      <= 1'b0;
      ptr_reg[0]   <= 8'h00;
      ptr_reg[1]   <= 8'h00;
      sda_oe       <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_tgt_reg   <= 1'b0;
      wr_addr_reg  <= 8'h00;
      wr_data_reg  <= 8'h00;
    end else begin
      wr_pulse_reg <= 1'b0;
      if (start_det) begin
        // Repeated start is accepted from any state
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe      <= 1'b0;
      end else if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_MACK) begin
          if (sda_s) begin
            state_reg <= ST_IDLE; // Host refused more data
          end
        end else if (state_reg != ST_IDLE && state_reg != ST_ACK_A && state_reg != ST_ACK_W && !byte_done) begin
          shift_reg   <= (state_reg == ST_RDATA) ? shift_reg : {shift_reg[6:0], sda_s};
          bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
        end
      end else if (scl_fall) begin
        unique case (state_reg)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (byte_done) begin
              if (shift_reg[7:1] == ADDR_ID || shift_reg[7:1] == ADDR_DIAG) begin
                tgt_reg   <= (shift_reg[7:1] == ADDR_DIAG);
                rw_reg    <= shift_reg[0];
                sda_oe    <= 1'b1;
                state_reg <= ST_ACK_A;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              shift_reg        <= rd_cur;
              sda_oe           <= !rd_cur[7];
              ptr_reg[tgt_reg] <= 8'(ptr_reg[tgt_reg] + 8'h01);
              state_reg        <= ST_RDATA;
            end else begin
              sda_oe    <= 1'b0;
              state_reg <= ST_WORD;
            end
          end
          ST_WORD: begin
            if (byte_done) begin
              ptr_reg[tgt_reg] <= shift_reg;
              sda_oe           <= 1'b1;
              state_reg        <= ST_ACK_W;
            end
          end
          ST_ACK_W: begin
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b0;
            state_reg   <= ST_WDATA;
          end
          ST_WDATA: begin
            if (byte_done) begin
              wr_pulse_reg     <= writable(tgt_reg, ptr_reg[tgt_reg]);
              wr_tgt_reg       <= tgt_reg;
              wr_addr_reg      <= ptr_reg[tgt_reg];
              wr_data_reg      <= shift_reg;
              ptr_reg[tgt_reg] <= 8'(ptr_reg[tgt_reg] + 8'h01);
              sda_oe           <= 1'b1; // Acknowledge even protected bytes
              state_reg        <= ST_ACK_W;
            end
          end
          ST_RDATA: begin
            if (byte_done) begin
              sda_oe    <= 1'b0;
              state_reg <= ST_MACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe    <= !shift_reg[6];
            end
          end
          ST_MACK: begin
            // Host acknowledged: next sequential byte
            bit_cnt_reg      <= 4'h0;
            shift_reg        <= rd_cur;
            sda_oe           <= !rd_cur[7];
            ptr_reg[tgt_reg] <= 8'(ptr_reg[tgt_reg] + 8'h01);
            state_reg        <= ST_RDATA;
          end
        endcase
      end
    end
  end

  // Identity memory: factory load only, the bus never writes it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        id_mem[i] <= 8'h00;
      end
    end else if (load.we && !load.diag_sel) begin
      id_mem[load.addr] <= load.data;
    end
  end

  // Diagnostics memory: factory load wins over a bus write in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        diag_mem[i] <= 8'h00;
      end
    end else if (load.we && load.diag_sel) begin
      diag_mem[load.addr] <= load.data;
    end else if (wr_pulse_reg && wr_tgt_reg) begin
      diag_mem[wr_addr_reg] <= wr_data_reg;
    end
  end

  // Range checks against stored thresholds; temperature compares signed
  always_comb begin
    logic [15:0] v;
    logic [7:0]  b;
    v          = 16'h0000;
    b          = 8'h00;
    alarm_next = 10'h000;
    warn_next  = 10'h000;
    for (int i = 0; i < NUM_MON; i++) begin
      v = mon_vec[79 - 16 * i -: 16];
      b = 8'(THR_STRIDE * 8'(i));
      alarm_next[9 - 2 * i] = cmp_gt(v, thr(b), i == 0);
      alarm_next[8 - 2 * i] = cmp_gt(thr(8'(b + THR_LO_ALARM)), v, i == 0);
      warn_next[9 - 2 * i]  = cmp_gt(v, thr(8'(b + THR_HI_WARN)), i == 0);
      warn_next[8 - 2 * i]  = cmp_gt(thr(8'(b + THR_LO_WARN)), v, i == 0);
    end
  end

  // Flags follow the live readings, one cycle late
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_reg <= 10'h000;
      warn_reg  <= 10'h000;
    end else begin
      alarm_reg <= alarm_next;
      warn_reg  <= warn_next;
    end
  end

  // Status pins; a floating laser-off input reads high through the pad pull-up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      no_light_flag <= 1'b1;
      rx_data_out   <= 1'b0;
      laser_enable  <= 1'b0;
      laser_trouble <= 1'b0;
    end else begin
      no_light_flag <= sync2_reg[3];
      rx_data_out   <= sync2_reg[2] && !sync2_reg[3];
      laser_enable  <= !sync2_reg[1];
      laser_trouble <= sync2_reg[0];
    end
  end

endmodule : mds_target

// >>> dv/mds_target_chk.sv
// Purpose: Port-level checks for the serial target and its status pins
// Assumes: Pins are asynchronous; two sync stages plus an output register
// Notes:   The ##[1:4] and [*5] windows carry one cycle of slack; the [*4] windows carry none
module mds_target_chk
  import mds_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Optical status pins
  input wire logic no_light_in,
  input wire logic rx_data_in,
  input wire logic no_light_flag,
  input wire logic rx_data_out,
  input wire logic laser_off_req,
  input wire logic laser_fault_in,
  input wire logic laser_enable,
  input wire logic laser_trouble
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Start marker: data falls while the clock is high
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  // Shutdown request edge
  sequence s_off_req;
    $rose(laser_off_req);
  endsequence
  a_start_quiet: assert property (s_start |=> !sda_oe [*4]) else $error("sda pulled after start");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved with scl high");
  a_sda_open: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_tx_off_time: assert property (s_off_req |-> ##[1:4] !laser_enable) else $error("laser off late");
  a_tx_off_hold: assert property (laser_off_req [*4] |-> !laser_enable) else $error("laser on");
  a_tx_on_low: assert property (!laser_off_req [*5] |-> laser_enable) else $error("laser off");
  a_no_light_hi: assert property (no_light_in [*4] |-> no_light_flag) else $error("flag low");
  a_no_light_lo: assert property (!no_light_in [*4] |-> !no_light_flag) else $error("flag high");
  a_rx_gated: assert property (no_light_flag && $past(no_light_flag) |-> !rx_data_out) else $error("rx leak");
  a_rx_pass: assert property ((!no_light_in && rx_data_in) [*5] |-> rx_data_out) else $error("rx lost");
  a_fault_on: assert property ($rose(laser_fault_in) |-> ##[1:4] laser_trouble) else $error("no trouble");
  a_fault_off: assert property ($fell(laser_fault_in) |-> ##[1:4] !laser_trouble) else $error("trouble");
endmodule : mds_target_chk

bind mds_target mds_target_chk u_mds_target_chk (
  .clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .no_light_in(no_light_in), .rx_data_in(rx_data_in), .no_light_flag(no_light_flag),
  .rx_data_out(rx_data_out), .laser_off_req(laser_off_req), .laser_fault_in(laser_fault_in),
  .laser_enable(laser_enable), .laser_trouble(laser_trouble));

// >>> dv/mds_host.sv
// Purpose: Host bus controller model driving the serial clock and framing
// Assumes: Line has a pull-up; 125 ns serial clock period
// Notes:   Clock rests high between frames
module mds_host (
  // Serial bus
  output logic      scl,
  output logic      sda_line,
  input  wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime Q = 31.25;
  logic drv;
  // Open-drain wire: high unless a side pulls low
  assign sda_line = drv & ~sda_oe;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // Clock toggles only inside a frame
  task automatic bit_out(input logic b);
    drv = b;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
    #Q;
  endtask : bit_out
  task automatic bit_in(output logic b);
    drv = 1'b1;
    #Q scl = 1'b1;
    #Q b = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_in
  // Data falls with clock high
  task automatic start();
    drv = 1'b1;
    #Q scl = 1'b1;
    #Q drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  // Data rises with clock high
  task automatic stop();
    drv = 1'b0;
    #Q scl = 1'b1;
    #Q drv = 1'b1;
    #Q;
  endtask : stop
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask : byte_wr
  task automatic byte_rd(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask : byte_rd
endmodule : mds_host

// >>> dv/mds_target_tb.sv
// Purpose: Self-checking bench for the serial target and status pins
// Assumes: Host model makes the serial clock; status pins driven on falling edge
// Notes:   Expected bytes are literals except CAL_INT_MASK; identity reads use literals, ID_DIAG_TYPE and USER_BASE; diagnostics reads use layout constants
module mds_target_tb
  import mds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, rst, scl, sda, sda_out, sda_oe, ok;
  logic       no_light_in, rx_data_in, no_light_flag, rx_data_out;
  logic       laser_off_req, laser_fault_in, laser_enable, laser_trouble;
  mds_mon_t   mon;
  mds_load_t  load;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  int         fails, checked;
  mds_target u_mds_target (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .no_light_in(no_light_in), .rx_data_in(rx_data_in), .no_light_flag(no_light_flag),
    .rx_data_out(rx_data_out), .laser_off_req(laser_off_req), .laser_fault_in(laser_fault_in),
    .laser_enable(laser_enable), .laser_trouble(laser_trouble), .mon(mon), .load(load));
  mds_host u_mds_host (.scl(scl), .sda_line(sda), .sda_oe(sda_oe));
  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Factory load, one-cycle strobe
  task automatic ld(input logic sel, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) load = '{1'b1, sel, a, d};
    @(negedge clock) load.we = 1'b0;
  endtask : ld
  // Word address then n bytes; n of 0 leaves the bus open for a repeated start
  task automatic wr(input logic [6:0] dev, input logic [7:0] wa, input int n, output logic all);
    logic a;
    u_mds_host.start();
    u_mds_host.byte_wr({dev, 1'b0}, all);
    u_mds_host.byte_wr(wa, a);
    all = all & a;
    for (int i = 0; i < n; i++) begin
      u_mds_host.byte_wr(wbuf[i], a);
      all = all & a;
    end
    if (n > 0) u_mds_host.stop();
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] wa, input int n);
    logic a;
    logic w;
    wr(dev, wa, 0, w);
    u_mds_host.start();
    u_mds_host.byte_wr({dev, 1'b1}, a);
    for (int i = 0; i < n; i++) u_mds_host.byte_rd(i == n - 1, rbuf[i]);
    u_mds_host.stop();
    chk("rd_ack", w & a, 1);
  endtask : rd
  // Status pins both ways, shutdown deadline counted
  task automatic t_status();
    int n;
    @(negedge clock) {laser_off_req, no_light_in, rx_data_in, laser_fault_in} = 4'h3;
    repeat (5) @(negedge clock);
    chk("status_on", {laser_enable, no_light_flag, rx_data_out, laser_trouble}, 4'hB);
    {laser_off_req, no_light_in, laser_fault_in} = 3'h6;
    n = 0;
    while (laser_enable !== 1'b0 && n < TX_OFF_CYCLES) begin
      @(negedge clock);
      n++;
    end
    chk("tx_off_late", n < TX_OFF_CYCLES, 1);
    if (n >= TX_OFF_CYCLES) end_sim();
    repeat (5) @(negedge clock);
    chk("status_off", {laser_enable, no_light_flag, rx_data_out, laser_trouble}, 4'h4);
    {laser_off_req, no_light_in} = 2'h0;
  endtask : t_status
  // Identity map: sequential, wrap, calibration bit, protected write
  task automatic t_ident();
    ld(1'b0, 8'h10, 8'hA5);
    ld(1'b0, 8'h11, 8'h3C);
    ld(1'b0, 8'hFF, 8'h77);
    ld(1'b0, 8'h00, 8'h12);
    rd(ADDR_ID, 8'h10, 2);
    chk("id_seq", {rbuf[0], rbuf[1]}, 16'hA53C);
    rd(ADDR_ID, 8'hFF, 2);
    chk("id_wrap", {rbuf[0], rbuf[1]}, 16'h7712);
    rd(ADDR_ID, ID_DIAG_TYPE, 1);
    chk("cal_int", rbuf[0] & CAL_INT_MASK, CAL_INT_MASK);
    wbuf[0] = 8'h00;
    wr(ADDR_ID, 8'h10, 1, ok);
    rd(ADDR_ID, 8'h10, 1);
    chk("id_prot", {ok, rbuf[0]}, 16'h01A5);
  endtask : t_ident
  // Diagnostics: live values, signed flags, protected thresholds, user area
  task automatic t_diag();
    ld(1'b1, 8'h00, 8'h10);
    mon.temp = 16'h1234;
    rd(ADDR_DIAG, LIVE_BASE, 2);
    chk("temp", {rbuf[0], rbuf[1]}, 16'h1234);
    rd(ADDR_DIAG, ALARM_BYTE0, 2);
    chk("alarm_hi", {rbuf[0], rbuf[1]}, 16'h8000);
    @(negedge clock) mon.temp = 16'hFF00;
    wbuf[0] = 8'hFF;
    wr(ADDR_DIAG, THR_LO_ALARM, 1, ok);
    rd(ADDR_DIAG, ALARM_BYTE0, 1);
    chk("alarm_lo", {ok, rbuf[0]}, 16'h0140);
    rd(ADDR_DIAG, WARN_BYTE0, 1);
    chk("warn_lo", rbuf[0], 8'h40);
    wbuf[0] = 8'h5A;
    wbuf[1] = 8'hC3;
    wr(ADDR_DIAG, USER_BASE, 2, ok);
    rd(ADDR_DIAG, USER_BASE, 2);
    chk("user", {rbuf[0], rbuf[1]}, 16'h5AC3);
    rd(ADDR_ID, USER_BASE, 1);
    chk("id_intact", rbuf[0], 8'h00);
  endtask : t_diag
  // Foreign address gets no acknowledge
  task automatic t_refuse();
    wr(7'h52, 8'h00, 1, ok);
    chk("foreign", ok, 0);
  endtask : t_refuse
  // Main sequence
  initial begin
    fails = 0;
    checked = 0;
    rst = 1'b1;
    {laser_off_req, no_light_in, rx_data_in, laser_fault_in} = 4'hC;
    mon = '0;
    load = '0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    // No false fault or light indication while the synchronisers fill
    repeat (5) begin
      @(negedge clock);
      chk("rst_status", {laser_enable, laser_trouble, no_light_flag}, 16'h0001);
    end
    t_status();
    t_ident();
    t_diag();
    t_refuse();
    end_sim();
  end
endmodule : mds_target_tb
